// ---- logic/cat_counter_array.sv ----
// Shared 16-bit counter of the programmable counter array with its mode register.
`default_nettype none
module cat_counter_array (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Special-function register port.
    input wire logic [1:0] sfrSelect,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    // Processor status.
    input wire logic cpuIdle,
    input wire logic controlRmwExec,
    input wire logic globalIrqEnable,
    input wire logic arrayIrqEnable,
    // Count sources.
    input wire logic timer0Overflow,
    input wire logic externalCountInput,
    input wire logic extOscillator,
    // Outputs to the processor and the capture/compare modules.
    output logic irqRequest,
    output logic [15:0] counterValue
);
    typedef struct packed {
        logic [7:0] countHigh;
        logic [7:0] countLow;
        logic [7:0] snapshot;
        logic [7:0] readData;
        logic idleStop;
        logic overflowFlag;
        logic [2:0] timebaseSelect;
        logic overflowIrqEnable;
    } cat_state_t;

    cat_state_t state;
    cat_state_t next_state;
    cat_tick_if tickLink ();
    logic [15:0] count;
    logic countTick;
    logic wrapNow;
    logic writeLow;
    logic writeHigh;
    logic writeMode;
    logic readLow;

    // Decode of a register access on the port.
    function automatic logic hits(input logic strobe, input logic [1:0] sel,
                                  input logic [1:0] target);
        hits = strobe && sel == target;
    endfunction : hits

    // Mode register image; reserved bits read as zero.
    function automatic logic [7:0] mode_image(input cat_state_t s);
        mode_image = 8'h00;
        mode_image[cat_pkg::CAT_MODE_IDLE_STOP_BIT] = s.idleStop;
        mode_image[cat_pkg::CAT_MODE_FLAG_BIT] = s.overflowFlag;
        mode_image[cat_pkg::CAT_MODE_SELECT_LSB +: 3] = s.timebaseSelect;
        mode_image[cat_pkg::CAT_MODE_IRQ_EN_BIT] = s.overflowIrqEnable;
    endfunction : mode_image

    cat_timebase timebase (
        .clk(clk),
        .reset(reset),
        .timer0Overflow(timer0Overflow),
        .externalCountInput(externalCountInput),
        .extOscillator(extOscillator),
        .link(tickLink)
    );

    // Link to the tick source; the counter halts in idle only when asked to.
    assign tickLink.timebaseSelect = state.timebaseSelect;
    assign tickLink.run = !(cpuIdle && state.idleStop);
    assign countTick = tickLink.tick;

    // Access strobes and the wrap condition.
    assign count = {state.countHigh, state.countLow};
    assign writeLow = hits(sfrWrite, sfrSelect, cat_pkg::CAT_SEL_COUNT_LOW);
    assign writeHigh = hits(sfrWrite, sfrSelect, cat_pkg::CAT_SEL_COUNT_HIGH);
    assign writeMode = hits(sfrWrite, sfrSelect, cat_pkg::CAT_SEL_MODE);
    assign readLow = hits(sfrRead, sfrSelect, cat_pkg::CAT_SEL_COUNT_LOW);
    assign wrapNow = countTick && !writeLow && !writeHigh && count == cat_pkg::CAT_COUNT_MAX;

    // Next state: counting, register writes, snapshot and read data.
    always_comb
    begin
        next_state = state;
        // A software write to a count byte wins over a tick in the same cycle.
        if (writeLow || writeHigh)
        begin
            if (writeLow)
            begin
                next_state.countLow = sfrWriteData;
            end
            if (writeHigh)
            begin
                next_state.countHigh = sfrWriteData;
            end
        end
        else if (countTick)
        begin
            {next_state.countHigh, next_state.countLow} = count + 16'h0001;
        end
        if (writeMode)
        begin
            next_state.idleStop = sfrWriteData[cat_pkg::CAT_MODE_IDLE_STOP_BIT];
            next_state.overflowFlag = sfrWriteData[cat_pkg::CAT_MODE_FLAG_BIT];
            next_state.timebaseSelect = sfrWriteData[cat_pkg::CAT_MODE_SELECT_LSB +: 3];
            next_state.overflowIrqEnable = sfrWriteData[cat_pkg::CAT_MODE_IRQ_EN_BIT];
        end
        // The hardware set wins over a software clear in the same cycle, but an
        // overflow that lands inside a control read-modify-write is lost.
        if (wrapNow && !controlRmwExec)
        begin
            next_state.overflowFlag = 1'b1;
        end
        // Reading the low byte freezes the high byte for the following read.
        if (readLow)
        begin
            next_state.snapshot = state.countHigh;
        end
        // Reads load the output register (a low read also the snapshot) and never touch the count.
        if (sfrRead)
        begin
            unique case (sfrSelect)
                cat_pkg::CAT_SEL_COUNT_LOW: next_state.readData = state.countLow;
                cat_pkg::CAT_SEL_COUNT_HIGH: next_state.readData = state.snapshot;
                cat_pkg::CAT_SEL_MODE: next_state.readData = mode_image(state);
                default: next_state.readData = cat_pkg::CAT_BYTE_RESET;
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state.countHigh <= cat_pkg::CAT_BYTE_RESET;
            state.countLow <= cat_pkg::CAT_BYTE_RESET;
            state.snapshot <= cat_pkg::CAT_BYTE_RESET;
            state.readData <= cat_pkg::CAT_BYTE_RESET;
            state.idleStop <= 1'b0;
            state.overflowFlag <= 1'b0;
            state.timebaseSelect <= cat_pkg::CAT_SELECT_RESET;
            state.overflowIrqEnable <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // The flag is never cleared by interrupt entry, only by a mode write.
    // Request needs the flag, its own enable, the array enable and the global one.
    assign irqRequest = state.overflowFlag && state.overflowIrqEnable
        && arrayIrqEnable && globalIrqEnable;
    assign sfrReadData = state.readData;
    // One copy of the count feeds all five capture/compare modules.
    assign counterValue = count;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence cat_low_read_s;
        readLow && !sfrWrite;
    endsequence

    sequence cat_high_read_s;
        hits(sfrRead, sfrSelect, cat_pkg::CAT_SEL_COUNT_HIGH);
    endsequence

    chk_tick_increment: assert property ((countTick && !writeLow && !writeHigh) |=> counterValue == $past(counterValue) + 16'h0001) else $error("Counter did not advance by one.");

    chk_wrap_sets_flag: assert property ((wrapNow && !controlRmwExec) |=> state.overflowFlag && counterValue == 16'h0000) else $error("Wrap did not set the flag.");

    chk_rmw_masks_flag: assert property ((wrapNow && controlRmwExec && !state.overflowFlag && !writeMode) |=> !state.overflowFlag) else $error("Flag set during read-modify-write.");

    chk_flag_sticky: assert property ((state.overflowFlag && !writeMode) |=> state.overflowFlag) else $error("Flag cleared without a write.");

    chk_irq_gating: assert property (irqRequest == (state.overflowFlag && state.overflowIrqEnable && arrayIrqEnable && globalIrqEnable)) else $error("Interrupt request gating wrong.");

    // A high read straight after the low read returns the high byte seen at the low read.
    chk_snapshot_read: assert property (
        (cat_low_read_s ##1 cat_high_read_s)
        |=> sfrReadData == $past(state.countHigh, 2))
        else $error("High read did not return snapshot.");

    // Software often leaves an idle cycle between the reads; the snapshot must still hold.
    chk_snapshot_gap: assert property (
        (cat_low_read_s ##1 !sfrRead ##1 cat_high_read_s)
        |=> sfrReadData == $past(state.countHigh, 3))
        else $error("High read after a gap did not return snapshot.");

    chk_idle_stop: assert property ((cpuIdle && state.idleStop && !writeLow && !writeHigh) |=> $stable(counterValue)) else $error("Counter moved in idle stop.");

    chk_idle_runs: assert property ((cpuIdle && !state.idleStop && state.timebaseSelect == cat_pkg::CAT_TB_SYSCLK && !sfrWrite) |=> counterValue != $past(counterValue)) else $error("Counter stalled in idle.");

    chk_read_no_effect: assert property ((sfrRead && !sfrWrite && !countTick) |=> $stable(counterValue)) else $error("Read disturbed the counter.");
endmodule : cat_counter_array
`default_nettype wire

// ---- inc/cat_pkg.sv ----
// Constants shared by the counter array timebase design.
`default_nettype none
package cat_pkg;
    // Register select codes on the special-function register port.
    localparam logic [1:0] CAT_SEL_COUNT_LOW = 2'h0;
    localparam logic [1:0] CAT_SEL_COUNT_HIGH = 2'h1;
    localparam logic [1:0] CAT_SEL_MODE = 2'h2;

    // Field positions inside the array mode register.
    localparam int CAT_MODE_IDLE_STOP_BIT = 7;
    localparam int CAT_MODE_FLAG_BIT = 6;
    localparam int CAT_MODE_SELECT_LSB = 1;
    localparam int CAT_MODE_IRQ_EN_BIT = 0;

    // Values after reset.
    localparam logic [15:0] CAT_COUNT_RESET = 16'h0000;
    localparam logic [2:0] CAT_SELECT_RESET = 3'h0;
    localparam logic [7:0] CAT_BYTE_RESET = 8'h00;

    // Timebase select codes.
    localparam logic [2:0] CAT_TB_DIV12 = 3'h0;
    localparam logic [2:0] CAT_TB_DIV4 = 3'h1;
    localparam logic [2:0] CAT_TB_TIMER0 = 3'h2;
    localparam logic [2:0] CAT_TB_EXT_INPUT = 3'h3;
    localparam logic [2:0] CAT_TB_SYSCLK = 3'h4;
    localparam logic [2:0] CAT_TB_OSC_DIV8 = 3'h5;

    // Divider counts in system clock cycles and oscillator edges, and the top value of the 16-bit count.
    localparam logic [3:0] CAT_PRESCALE_LAST = 4'hb;
    localparam logic [1:0] CAT_DIV4_PHASE = 2'h3;
    localparam logic [2:0] CAT_OSC_DIV_LAST = 3'h7;
    localparam logic [15:0] CAT_COUNT_MAX = 16'hffff;
endpackage : cat_pkg
`default_nettype wire

// ---- inc/cat_tick_if.sv ----
// Link between the counter core and its timebase tick source.
`default_nettype none
interface cat_tick_if;
    logic [2:0] timebaseSelect;
    logic run;
    logic tick;
    modport counter (output timebaseSelect, output run, input tick);
    modport source (input timebaseSelect, input run, output tick);
endinterface : cat_tick_if
`default_nettype wire

// ---- logic/cat_timebase.sv ----
// Timebase tick generator for the counter array.
`default_nettype none
module cat_timebase (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Count sources.
    input wire logic timer0Overflow,
    input wire logic externalCountInput,
    input wire logic extOscillator,
    // Link to the counter core.
    cat_tick_if.source link
);
    typedef struct packed {
        logic [3:0] prescale;
        logic countInPrev;
        logic oscMeta;
        logic oscSync;
        logic oscPrev;
        logic [2:0] oscDiv;
    } cat_tb_state_t;

    cat_tb_state_t state;
    cat_tb_state_t next_state;
    logic oscRise;
    logic countInFall;

    // The oscillator is asynchronous, so only the second stage feeds the edge detector.
    assign oscRise = state.oscSync && !state.oscPrev;
    assign countInFall = state.countInPrev && !externalCountInput;

    // Next state of the prescaler, the edge detectors and the divide-by-8 counter.
    always_comb
    begin
        next_state = state;
        next_state.countInPrev = externalCountInput;
        next_state.oscMeta = extOscillator;
        next_state.oscSync = state.oscMeta;
        next_state.oscPrev = state.oscSync;
        if (state.prescale == cat_pkg::CAT_PRESCALE_LAST)
        begin
            next_state.prescale = 4'h0;
        end
        else
        begin
            next_state.prescale = state.prescale + 4'h1;
        end
        if (oscRise)
        begin
            next_state.oscDiv = state.oscDiv + 3'h1;
        end
    end

    // One shared prescaler serves both system clock dividers, saving a counter.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Tick selection; codes 110 and 111 give no tick at all.
    always_comb
    begin
        unique case (link.timebaseSelect)
            cat_pkg::CAT_TB_DIV12: link.tick = state.prescale == cat_pkg::CAT_PRESCALE_LAST;
            cat_pkg::CAT_TB_DIV4: link.tick = state.prescale[1:0] == cat_pkg::CAT_DIV4_PHASE;
            cat_pkg::CAT_TB_TIMER0: link.tick = timer0Overflow;
            cat_pkg::CAT_TB_EXT_INPUT: link.tick = countInFall;
            cat_pkg::CAT_TB_SYSCLK: link.tick = 1'b1;
            cat_pkg::CAT_TB_OSC_DIV8: link.tick = oscRise && state.oscDiv == cat_pkg::CAT_OSC_DIV_LAST;
            default: link.tick = 1'b0;
        endcase
        link.tick = link.tick && link.run;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_sysclk_tick: assert property ((link.run && link.timebaseSelect == cat_pkg::CAT_TB_SYSCLK) |-> link.tick) else $error("Undivided timebase missed a tick.");

    // A new select may tick at once, so only ticks still under divide-by-4 are spaced.
    chk_div4_spacing: assert property (
        (link.tick && link.timebaseSelect == cat_pkg::CAT_TB_DIV4
            && $stable(link.timebaseSelect))
        |=> (!link.tick || link.timebaseSelect != cat_pkg::CAT_TB_DIV4)[*3])
        else $error("Divide-by-4 ticks too close.");
endmodule : cat_timebase
`default_nettype wire

// ---- verif/cat_source_model.sv ----
// Behavioural model of the count sources that feed the counter array.
`default_nettype none
module cat_source_model (
    // Clock.
    input wire logic clk,
    // Count sources.
    output logic timer0Overflow,
    output logic externalCountInput,
    output logic extOscillator
);
    timeunit 1ns;
    timeprecision 1ns;
    int phase = 0;

    // Timer 0 pulses every fifth clock; the count input toggles every second clock.
    initial
    begin
        timer0Overflow = 1'b0;
        externalCountInput = 1'b1;
        forever
        begin
            @(negedge clk);
            phase = phase + 1;
            timer0Overflow = (phase % 5 == 0);
            if (phase % 2 == 0)
                externalCountInput = !externalCountInput;
        end
    end

    // The oscillator runs at 4 MHz, below the system clock, and is not phase locked to it.
    // An odd start phase keeps every oscillator edge off both clock edges, so no race.
    initial
    begin
        extOscillator = 1'b0;
        #7;
        forever
            #125 extOscillator = !extOscillator;
    end
endmodule : cat_source_model
`default_nettype wire

// ---- verif/cat_counter_array_timebase_tb.sv ----
// Self-checking bench for the counter array with its count source model.
`default_nettype none
`define CHK(act, exp) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); \
        end \
    end
module cat_counter_array_timebase_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sfrSelect = 2'h0;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrWriteData = 8'h00;
    logic [7:0] sfrReadData;
    logic cpuIdle = 1'b0;
    logic controlRmwExec = 1'b0;
    logic globalIrqEnable = 1'b0;
    logic arrayIrqEnable = 1'b0;
    logic timer0Overflow;
    logic externalCountInput;
    logic extOscillator;
    logic irqRequest;
    logic [15:0] counterValue;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    cat_counter_array dut (.clk(clk), .reset(reset), .sfrSelect(sfrSelect),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
        .sfrReadData(sfrReadData), .cpuIdle(cpuIdle), .controlRmwExec(controlRmwExec),
        .globalIrqEnable(globalIrqEnable), .arrayIrqEnable(arrayIrqEnable),
        .timer0Overflow(timer0Overflow), .externalCountInput(externalCountInput),
        .extOscillator(extOscillator), .irqRequest(irqRequest),
        .counterValue(counterValue));

    cat_source_model src (.clk(clk), .timer0Overflow(timer0Overflow),
        .externalCountInput(externalCountInput), .extOscillator(extOscillator));

    // System clock of 100 ns period.
    initial
    begin
        forever
            #50 clk = ~clk;
    end

    // A hang is cut short well past the expected run of about 860 cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Register cycles: a one-cycle strobe, read data taken one cycle after the read edge.
    task automatic wr(input logic [1:0] sel, input logic [7:0] data);
        @(negedge clk);
        sfrSelect = sel;
        sfrWriteData = data;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] sel, output logic [7:0] data);
        @(negedge clk);
        sfrSelect = sel;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        data = sfrReadData;
    endtask : rd

    task automatic t_regs;
        logic [7:0] d;
        rd(cat_pkg::CAT_SEL_MODE, d);
        `CHK(d, 8'h00)
        rd(2'h3, d);
        `CHK(d, 8'h00)
    endtask : t_regs

    // Every window is a whole number of timebase periods; each count is checked exactly except the oscillator one, which may be one tick off.
    task automatic t_rates;
        int win[8] = '{120, 40, 50, 40, 10, 200, 50, 50};
        logic [15:0] c0;
        logic [15:0] d;
        for (int i = 0; i < 8; i++)
        begin
            wr(cat_pkg::CAT_SEL_MODE, {4'h0, 3'(i), 1'b0});
            repeat (24) @(negedge clk);
            c0 = counterValue;
            repeat (win[i]) @(negedge clk);
            d = counterValue - c0;
            if (i == 5)
                `CHK(d >= 16'h0009 && d <= 16'h000b, 1'b1)
            else
                `CHK(d, (i > 5) ? 16'h0000 : 16'h000a)
        end
    endtask : t_rates

    task automatic t_snapshot;
        logic [7:0] d;
        logic [15:0] c0;
        wr(cat_pkg::CAT_SEL_MODE, 8'h0c);
        wr(cat_pkg::CAT_SEL_COUNT_HIGH, 8'h12);
        wr(cat_pkg::CAT_SEL_COUNT_LOW, 8'hfe);
        rd(cat_pkg::CAT_SEL_COUNT_LOW, d);
        `CHK(d, 8'hfe)
        wr(cat_pkg::CAT_SEL_COUNT_HIGH, 8'h34);
        rd(cat_pkg::CAT_SEL_COUNT_HIGH, d);
        `CHK(d, 8'h12)
        `CHK(counterValue, 16'h34fe)
        wr(cat_pkg::CAT_SEL_MODE, 8'h08);
        c0 = counterValue;
        rd(cat_pkg::CAT_SEL_COUNT_LOW, d);
        rd(cat_pkg::CAT_SEL_COUNT_HIGH, d);
        rd(cat_pkg::CAT_SEL_COUNT_HIGH, d);
        `CHK(counterValue - c0, 16'h0006)
    endtask : t_snapshot

    task automatic t_overflow;
        logic [7:0] d;
        logic [15:0] c0;
        wr(cat_pkg::CAT_SEL_MODE, 8'h0c);
        wr(cat_pkg::CAT_SEL_COUNT_HIGH, 8'hff);
        wr(cat_pkg::CAT_SEL_COUNT_LOW, 8'hff);
        cpuIdle = 1'b1;
        wr(cat_pkg::CAT_SEL_MODE, 8'h09);
        @(negedge clk);
        `CHK(counterValue, 16'h0000)
        for (int i = 0; i < 4; i++)
        begin
            {globalIrqEnable, arrayIrqEnable} = 2'(i);
            @(negedge clk);
            `CHK(irqRequest, i == 3)
        end
        wr(cat_pkg::CAT_SEL_MODE, 8'h48);
        `CHK(irqRequest, 1'b0)
        rd(cat_pkg::CAT_SEL_MODE, d);
        `CHK(d[6], 1'b1)
        wr(cat_pkg::CAT_SEL_MODE, 8'h08);
        rd(cat_pkg::CAT_SEL_MODE, d);
        `CHK(d[6], 1'b0)
        wr(cat_pkg::CAT_SEL_MODE, 8'h88);
        c0 = counterValue;
        repeat (5) @(negedge clk);
        `CHK(counterValue, c0)
        cpuIdle = 1'b0;
    endtask : t_overflow

    // The wrap falls inside a control update; software then repairs the lost flag.
    task automatic t_rmw;
        logic [7:0] d;
        logic [7:0] h1;
        logic [7:0] h2;
        wr(cat_pkg::CAT_SEL_MODE, 8'h0c);
        wr(cat_pkg::CAT_SEL_COUNT_HIGH, 8'hff);
        wr(cat_pkg::CAT_SEL_COUNT_LOW, 8'hfd);
        rd(cat_pkg::CAT_SEL_COUNT_LOW, d);
        rd(cat_pkg::CAT_SEL_COUNT_HIGH, h1);
        controlRmwExec = 1'b1;
        wr(cat_pkg::CAT_SEL_MODE, 8'h08);
        repeat (4) @(negedge clk);
        controlRmwExec = 1'b0;
        rd(cat_pkg::CAT_SEL_MODE, d);
        `CHK(d[6], 1'b0)
        rd(cat_pkg::CAT_SEL_COUNT_LOW, d);
        rd(cat_pkg::CAT_SEL_COUNT_HIGH, h2);
        `CHK({h1, h2}, 16'hff00)
        if (h1 == 8'hff && h2 == 8'h00)
            wr(cat_pkg::CAT_SEL_MODE, 8'h48);
        rd(cat_pkg::CAT_SEL_MODE, d);
        `CHK(d[6], 1'b1)
    endtask : t_rmw

    // Main sequence: reset for 12 cycles, then each scenario in turn.
    initial
    begin
        repeat (12) @(negedge clk);
        `CHK(counterValue, 16'h0000)
        reset = 1'b0;
        t_regs();
        t_rates();
        t_snapshot();
        t_overflow();
        t_rmw();
        wrap_up();
    end
endmodule : cat_counter_array_timebase_tb
`default_nettype wire
